// ==== core/pdg_mux_map.vh ====
`ifndef PDG_MUX_MAP_VH
`define PDG_MUX_MAP_VH

// Register byte offsets, one aligned word each
`define PDG_OFF_D_LOW 8'h00
`define PDG_OFF_D_HIGH 8'h04
`define PDG_OFF_E_LOW 8'h08
`define PDG_OFF_E_HIGH 8'h0C
`define PDG_OFF_F_LOW 8'h10
`define PDG_OFF_F_HIGH 8'h14
`define PDG_OFF_G_LOW 8'h18
`define PDG_OFF_G_HIGH 8'h1C
`define PDG_ADDR_W 8
`define PDG_REG_COUNT 8

// Reset values
`define PDG_SEL_RESET 8'h00

// Writable bits per register; port D high bits 7:6 unimplemented
`define PDG_WMASK_FULL 8'hFF
`define PDG_WMASK_D_HIGH 8'h3F

// Pin index: port D 0..7, E 8..15, F 16..23, G 24..31
`define PDG_PINS 32

// Pins that act as GPIO under selection code 00, 01, 10, 11
`define PDG_GPIO_CODE0 32'hFFFFFFFF
`define PDG_GPIO_CODE1 32'hFF3CF400
`define PDG_GPIO_CODE2 32'h0F10F000
`define PDG_GPIO_CODE3 32'h00000000

// GPIO pins that also feed a timer clock or interrupt input
`define PDG_AUX_IN_MASK 32'h005F042B

// AXI responses
`define PDG_RESP_OKAY 2'h0
`define PDG_RESP_DECERR 2'h3

`endif

// ==== core/pdg_mux.v ====
// Design decisions made here: the address map and register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
`include "pdg_mux_map.vh"

//
// Contract
// - PD3 field: GPIO+PT clk2, PT7, AN11, SEG33
// - PD2 field: GPIO, PT2, UART1 TX, AN10
// - PD1 field: GPIO+ST clk1, UART1 RX/TX, AN9, SEG34
// - PD0 code 00: GPIO with interrupt 2
// - Port D high bits 7:6 read zero
// - PD6 field: GPIO, ST2, C1 out, SEG27
// - PD5 field: GPIO+PT clk3, UART0 TX, C1+, SEG32
// - PD4 field: GPIO, PT3, UART0 RX/TX, C1-
// - PE2 field: GPIO+PT clk1 twice, SPI SDI, SEG5
// - PE1 field: GPIO, ST0, SPI SDO, SEG6
// - PE7..5: GPIO, GPIO, reserved, SEG43..45
// - PE4: GPIO for 00..10, IO supply 11
// - PF3: GPIO+PT clk7 twice, SCK/SCL, SEG10
// - PF2: GPIO+PT clk6 twice, SDI/SDA, SEG11
// - PF1: GPIO+PT clk5, PT6, SDO, SEG12
// - PF0: GPIO+PT clk4, PT7, chip select, SEG13
// - PF6: GPIO+ST clk2, UART1 RX/TX, C0-, SEG31
// - PF5: GPIO twice, PT0, crystal pin 1
// - PF4: GPIO+PT clk0 thrice, crystal pin 2
// - PG3..0: GPIO thrice, then COM3..0
// - PG7..4: GPIO twice, COM7..4, SEG3..0
module pdg_mux (
    input wire clock,
    input wire rst,
    // AXI4-Lite slave
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // Package pins, three signals each
    input wire [31:0] pin_in,
    output wire [31:0] pin_out,
    output wire [31:0] pin_oe,
    // GPIO port logic
    input wire [31:0] gpio_out,
    input wire [31:0] gpio_oe,
    output wire [31:0] gpio_in,
    // Timer clock and interrupt inputs beside GPIO
    output wire [31:0] aux_in,
    // Alternate functions for codes 01, 10, 11
    input wire [31:0] alt1_out,
    input wire [31:0] alt1_oe,
    output wire [31:0] alt1_in,
    input wire [31:0] alt2_out,
    input wire [31:0] alt2_oe,
    output wire [31:0] alt2_in,
    input wire [31:0] alt3_out,
    input wire [31:0] alt3_oe,
    output wire [31:0] alt3_in,
    // Set for every non-GPIO selection, digital alternates such as UART or timer included
    output wire [31:0] analog_en,
    // Raw selection codes, two bits per pin
    output wire [63:0] pin_sel
);

////////////////////////////////////////////////////////////////////////////////
// Address decode

function [3:0] pdg_decode;
    input [7:0] addr;
    begin
        // Bit 3 flags a valid hit, bits 2:0 the index
        if (addr[7:5] == 3'h0 && addr[1:0] == 2'h0) begin
            pdg_decode = {1'b1, addr[4:2]};
        end else begin
            pdg_decode = 4'h0;
        end
    end
endfunction

function [7:0] pdg_wmask;
    input [2:0] idx;
    begin
        if (idx == 3'h1) begin
            pdg_wmask = `PDG_WMASK_D_HIGH;
        end else begin
            pdg_wmask = `PDG_WMASK_FULL;
        end
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Selection registers

reg [7:0] sel_r [0:7];
wire [3:0] wr_dec;
wire [3:0] rd_dec;
wire wr_go;
wire rd_go;

assign wr_dec = pdg_decode(s_axi_awaddr);
assign rd_dec = pdg_decode(s_axi_araddr);

// Address and data taken together; one write in flight
assign wr_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
assign s_axi_awready = wr_go;
assign s_axi_wready = wr_go;
assign rd_go = s_axi_arvalid & ~s_axi_rvalid;
assign s_axi_arready = rd_go;

integer i;
always @(posedge clock or posedge rst) begin
    if (rst) begin
        for (i = 0; i < `PDG_REG_COUNT; i = i + 1) begin
            sel_r[i] <= `PDG_SEL_RESET;
        end
    end else if (wr_go && wr_dec[3] && s_axi_wstrb[0]) begin
        // Unimplemented bits never store, so they read zero
        sel_r[wr_dec[2:0]] <= s_axi_wdata[7:0] & pdg_wmask(wr_dec[2:0]);
    end
end

always @(posedge clock or posedge rst) begin
    if (rst) begin
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `PDG_RESP_OKAY;
    end else if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_dec[3] ? `PDG_RESP_OKAY : `PDG_RESP_DECERR;
    end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
    end
end

always @(posedge clock or posedge rst) begin
    if (rst) begin
        s_axi_rvalid <= 1'b0;
        s_axi_rresp <= `PDG_RESP_OKAY;
        s_axi_rdata <= 32'h00000000;
    end else if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        if (rd_dec[3]) begin
            s_axi_rresp <= `PDG_RESP_OKAY;
            s_axi_rdata <= {24'h000000, sel_r[rd_dec[2:0]]};
        end else begin
            s_axi_rresp <= `PDG_RESP_DECERR;
            s_axi_rdata <= 32'h00000000;
        end
    end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
    end
end

assign pin_sel = {sel_r[7], sel_r[6], sel_r[5], sel_r[4],
                  sel_r[3], sel_r[2], sel_r[1], sel_r[0]};

////////////////////////////////////////////////////////////////////////////////
// Pin input synchroniser: the whole bus updates only once stages two and three agree on all 32 bits

reg [31:0] sync1_r;
reg [31:0] sync2_r;
reg [31:0] sync3_r;
reg [31:0] pin_in_r;
wire [31:0] pin_in_nxt;

assign pin_in_nxt = (sync2_r == sync3_r) ? sync3_r : pin_in_r;

always @(posedge clock or posedge rst) begin
    if (rst) begin
        sync1_r <= 32'h00000000;
        sync2_r <= 32'h00000000;
        sync3_r <= 32'h00000000;
        pin_in_r <= 32'h00000000;
    end else begin
        sync1_r <= pin_in;
        sync2_r <= sync1_r;
        sync3_r <= sync2_r;
        pin_in_r <= pin_in_nxt;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Per-pin function mux

localparam [31:0] GPIO_C0 = `PDG_GPIO_CODE0;
localparam [31:0] GPIO_C1 = `PDG_GPIO_CODE1;
localparam [31:0] GPIO_C2 = `PDG_GPIO_CODE2;
localparam [31:0] GPIO_C3 = `PDG_GPIO_CODE3;
localparam [31:0] AUX_MASK = `PDG_AUX_IN_MASK;

genvar p;
generate
    for (p = 0; p < `PDG_PINS; p = p + 1) begin : g_pin
        wire [1:0] code;
        wire is_gpio;
        assign code = pin_sel[2 * p + 1:2 * p];
        // Reserved code on PE7..5 falls back to GPIO, pin stays safe
        assign is_gpio = (code == 2'h0) ? GPIO_C0[p] :
                         (code == 2'h1) ? GPIO_C1[p] :
                         (code == 2'h2) ? GPIO_C2[p] :
                         GPIO_C3[p];
        // Only the selected source drives the pin
        assign pin_out[p] = is_gpio ? gpio_out[p] :
                            (code == 2'h1) ? alt1_out[p] :
                            (code == 2'h2) ? alt2_out[p] : alt3_out[p];
        assign pin_oe[p] = is_gpio ? gpio_oe[p] :
                           (code == 2'h1) ? alt1_oe[p] :
                           (code == 2'h2) ? alt2_oe[p] : alt3_oe[p];
        // Unselected consumers see a quiet zero
        assign gpio_in[p] = is_gpio & pin_in_r[p];
        assign aux_in[p] = is_gpio & AUX_MASK[p] & pin_in_r[p];
        assign alt1_in[p] = ~is_gpio & (code == 2'h1) & pin_in_r[p];
        assign alt2_in[p] = ~is_gpio & (code == 2'h2) & pin_in_r[p];
        assign alt3_in[p] = ~is_gpio & (code == 2'h3) & pin_in_r[p];
        assign analog_en[p] = ~is_gpio;
        // Port D pin 7 has no field bits: code stays 00, always GPIO
    end
endgenerate

endmodule
`default_nettype wire

// ==== tb/pdg_mux_chk.sv ====
`timescale 1ns/10ps
`default_nettype none
module pdg_mux_chk (
    input wire logic clock,
    input wire logic rst,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic [31:0] pin_out,
    input wire logic [31:0] gpio_out,
    input wire logic [31:0] analog_en,
    input wire logic [63:0] pin_sel
);
    default clocking dc @(posedge clock); endclocking
    default disable iff (rst);
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready
        && s_axi_wvalid |=> s_axi_bvalid) else $error("no write answer");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid) else $error("no read answer");
    a_one_write: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("second write taken");
    a_dhigh_zero: assert property (pin_sel[15:14] == 2'b00)
        else $error("unimplemented bits set");
    a_pd0_gpio: assert property (pin_sel[1:0] == 2'b00 |->
        pin_out[0] == gpio_out[0] && !analog_en[0]) else $error("pd0 route");
    a_pd3_segment: assert property (pin_sel[7:6] == 2'b11 |->
        analog_en[3]) else $error("pd3 segment");
    a_pg0_gpio: assert property (pin_sel[49:48] == 2'b10 |->
        !analog_en[24]) else $error("pg0 route");
    a_pg7_common: assert property (pin_sel[63:62] == 2'b10 |->
        analog_en[31]) else $error("pg7 common");
    a_pd7_gpio: assert property (pin_out[7] == gpio_out[7])
        else $error("pd7 route");
    cover property (pin_sel[7:6] == 2'b11);
    cover property (pin_sel[63:62] == 2'b10);
    cover property (s_axi_bvalid);
endmodule
bind pdg_mux pdg_mux_chk u_chk (.clock, .rst, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .pin_out, .gpio_out, .analog_en, .pin_sel);
`default_nettype wire

// ==== tb/pdg_pins.sv ====
`timescale 1ns/10ps
`default_nettype none
module pdg_pins (
    input wire logic [31:0] pin_out,
    input wire logic [31:0] pin_oe,
    input wire logic [31:0] ext,
    output logic [31:0] pin_in
);
    // Released pins take the board level, which the bench keeps changing
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
endmodule
`default_nettype wire

// ==== tb/pdg_mux_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module pdg_mux_tb;
    logic clock = 0, rst = 1, s_axi_awvalid = 0, s_axi_wvalid = 0;
    logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, d;
    logic [31:0] s_axi_wdata = 0, ext = 0, q;
    logic [31:0] so [4] = '{default: 0}, se [4] = '{default: 0};
    logic [7:0] shadow [8] = '{default: 0};
    logic [1:0] r;
    int n_mismatch = 0, checked = 0, cyc = 0, i;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid;
    wire s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata, pin_out, pin_oe, pin_in, gpio_in, analog_en;
    wire [63:0] pin_sel;
    wire [31:0] aux_in, alt1_in, alt2_in, alt3_in;
    localparam logic [31:0] AUXM = 32'h005F042B;
    wire [31:0] gpio_out = so[0], alt1_out = so[1], alt2_out = so[2];
    wire [31:0] alt3_out = so[3], gpio_oe = se[0], alt1_oe = se[1];
    wire [31:0] alt2_oe = se[2], alt3_oe = se[3];
    pdg_mux DUT (.*, .s_axi_wstrb(4'hF));
    pdg_pins u_pins (.pin_out, .pin_oe, .ext, .pin_in);
    ////////////////////////////////////////////////////////////////////
    task automatic cmp(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim;
        $display("checked %0d n_mismatch %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, v};
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        do @(posedge clock); while (!(s_axi_awready && s_axi_wready));
        s_axi_awvalid <= 0;
        s_axi_wvalid <= 0;
        s_axi_bready <= 1;
        do @(posedge clock); while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 0;
    endtask
    task automatic rd(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        do @(posedge clock); while (!s_axi_arready);
        s_axi_arvalid <= 0;
        s_axi_rready <= 1;
        do @(posedge clock); while (!s_axi_rvalid);
        q = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 0;
    endtask
    // Pins acting as plain port bits, per selection code
    function automatic logic [31:0] gmask(input logic [1:0] c);
        case (c)
            2'h0: return 32'hFFFFFFFF;
            2'h1: return 32'hFF3CF400;
            2'h2: return 32'h0F10F000;
            default: return 32'h0;
        endcase
    endfunction
    // Level at the pin follows the selected driver, else the board
    task automatic chk_pins;
        logic [1:0] c;
        logic [31:0] m;
        logic lv;
        int k;
        for (int p = 0; p < 32; p++) begin
            c = shadow[p / 4][2 * (p % 4) +: 2];
            m = gmask(c);
            k = m[p] ? 0 : c;
            lv = se[k][p] ? so[k][p] : ext[p];
            cmp({24'h0, pin_oe[p], pin_out[p], analog_en[p], gpio_in[p],
                aux_in[p], alt1_in[p], alt2_in[p], alt3_in[p]},
                {24'h0, se[k][p], so[k][p], !m[p], m[p] & lv,
                m[p] & AUXM[p] & lv, !m[p] & (c == 2'h1) & lv,
                !m[p] & (c == 2'h2) & lv, !m[p] & (c == 2'h3) & lv});
        end
    endtask
    ////////////////////////////////////////////////////////////////////
    initial forever #4 clock = ~clock;
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_mismatch++;
            end_sim;
        end
    end
    initial begin
        void'($urandom(32'h06CA));
        repeat (20) @(posedge clock);
        rst <= 0;
        for (i = 0; i < 8; i++) begin
            rd(8'(4 * i));
            cmp(q, 32'h0);
        end
        rd(8'h20);
        cmp({30'h0, r}, 32'h3);
        wr(8'h02, 8'hFF);
        cmp({30'h0, r}, 32'h3);
        rd(8'h00);
        cmp(q, 32'h0);
        // Every code on every field first, except code 10 on PE7..5 which turns into 11, then random settings
        for (int n = 0; n < 48; n++) begin
            i = n < 32 ? n % 8 : $urandom % 8;
            d = n < 32 ? 8'(8'h55 * (n / 8)) : 8'($urandom);
            if (i == 3)
                d = d | ((d & 8'hA8) >> 1);
            wr(8'(4 * i), d);
            cmp({30'h0, r}, 32'h0);
            shadow[i] = d & (i == 1 ? 8'h3F : 8'hFF);
            rd(8'(4 * i));
            cmp(q, {24'h0, shadow[i]});
            for (int k = 0; k < 4; k++) begin
                so[k] <= $urandom;
                se[k] <= $urandom;
            end
            ext <= $urandom;
            repeat (5) @(posedge clock);
            chk_pins;
        end
        end_sim;
    end
endmodule
`default_nettype wire
